// file: omm_pkg.sv
/*
 * Constants for the operating mode manager: register offsets, field
 * positions, reset values, mode codes and the system reset timing.
 * Assumes a 200 MHz clock and an 8-bit register port.
 */
`default_nettype none
package omm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [7:0] ADDR_SYS_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SYS_RESET = 8'h01;
	localparam logic [7:0] ADDR_SYS_CLOCK = 8'h02;
	localparam logic [7:0] ADDR_TRIM_FIRST = 8'h03;
	localparam logic [7:0] ADDR_TRIM_SECOND = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h05;

	// Field positions.
	localparam int CTRL_SLEEP_ALLOW = 7;
	localparam int CTRL_PCONF_ALLOW = 6;
	localparam int CTRL_BUSERR_EN = 5;
	localparam int CTRL_WDOG_EN = 4;
	localparam int RST_SLEEP_REQ = 0;
	localparam int RST_SLEPT = 1;
	localparam int CLK_EXT_SEL = 0;
	localparam int CLK_RC_BIAS = 1;
	localparam int CLK_CPU_LSB = 2;
	localparam int CLK_CPU_MSB = 3;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_RW_MASK = 8'hF0;
	localparam logic EXT_SEL_RESET = 1'b0;
	localparam logic RC_BIAS_RESET = 1'b1;
	localparam logic [1:0] CPU_CLK_RESET = 2'h0;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam logic [15:0] BOOT_ADDR = 16'h0000;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// System reset pulse width: a least time, so it rounds up.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYS_RESET_NS = 50;
	localparam int SYS_RESET_CYCLES =
		(SYS_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_CNT_W = 4;

	typedef enum logic [1:0] {
		OMM_ACTIVE = 2'b00,
		OMM_STANDBY = 2'b01,
		OMM_SLEEP = 2'b10,
		OMM_RESET = 2'b11
	} omm_mode_e;
endpackage
`default_nettype wire

// file: omm_cold_regs.sv
/*
 * Cold reset domain register bank: system control, clock source select,
 * RC bias and both RC trims. Only power-on reset clears these bits.
 * Assumes one-cycle write strobes from the register decoder.
 */
`timescale 1ns/1ps
`default_nettype none
module omm_cold_regs (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// Write strobes and data
	input wire logic wr_ctrl,
	input wire logic wr_clock,
	input wire logic wr_trim_first,
	input wire logic wr_trim_second,
	input wire logic [7:0] wdata,
	// Stored values
	output logic [7:0] system_control_reg,
	output logic external_clock_select,
	output logic rc_bias_keep,
	output logic [7:0] rc_trim_first,
	output logic [7:0] rc_trim_second
);
	logic [7:0] next_ctrl;
	logic next_ext;
	logic next_bias;
	logic [7:0] next_trim1;
	logic [7:0] next_trim2;

	always_comb begin
		next_ctrl = system_control_reg;
		next_ext = external_clock_select;
		next_bias = rc_bias_keep;
		next_trim1 = rc_trim_first;
		next_trim2 = rc_trim_second;
		if (wr_ctrl) begin
			next_ctrl = wdata & omm_pkg::CTRL_RW_MASK;
			// The watchdog enable is sticky: software cannot clear it.
			next_ctrl[omm_pkg::CTRL_WDOG_EN] =
				system_control_reg[omm_pkg::CTRL_WDOG_EN] |
				wdata[omm_pkg::CTRL_WDOG_EN];
		end
		if (wr_clock) begin
			next_ext = wdata[omm_pkg::CLK_EXT_SEL];
			next_bias = wdata[omm_pkg::CLK_RC_BIAS];
		end
		if (wr_trim_first) begin
			next_trim1 = wdata;
		end
		if (wr_trim_second) begin
			next_trim2 = wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			system_control_reg <= omm_pkg::CTRL_RESET;
			external_clock_select <= omm_pkg::EXT_SEL_RESET;
			rc_bias_keep <= omm_pkg::RC_BIAS_RESET;
			rc_trim_first <= omm_pkg::TRIM_RESET;
			rc_trim_second <= omm_pkg::TRIM_RESET;
		end else begin
			// No system reset input here, so a wake keeps these bits.
			system_control_reg <= next_ctrl;
			external_clock_select <= next_ext;
			rc_bias_keep <= next_bias;
			rc_trim_first <= next_trim1;
			rc_trim_second <= next_trim2;
		end
	end
endmodule
`default_nettype wire

// file: omm_reset_stretch.sv
/*
 * Stretches a system reset request into a pulse of fixed length.
 * Assumes the trigger is synchronous; a new trigger restarts the count.
 */
`timescale 1ns/1ps
`default_nettype none
module omm_reset_stretch (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// Request and stretched level
	input wire logic trigger,
	output logic active
);
	logic [omm_pkg::RST_CNT_W-1:0] count;
	logic [omm_pkg::RST_CNT_W-1:0] next_count;
	logic next_active;

	localparam logic [omm_pkg::RST_CNT_W-1:0] LOAD =
		omm_pkg::RST_CNT_W'(omm_pkg::SYS_RESET_CYCLES);

	always_comb begin
		next_count = count;
		if (trigger) begin
			next_count = LOAD;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
		next_active = (next_count != '0);
	end

	// The count starts loaded so the CPU leaves power-on reset held.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= LOAD;
			active <= 1'b1;
		end else begin
			count <= next_count;
			active <= next_active;
		end
	end
endmodule
`default_nettype wire

// file: omm_top.sv
/*
 * Operating mode manager: start-up, system reset, active, standby and
 * sleep modes, wake-up from sleep and the slept indicator, with the
 * system registers behind a plain one-cycle register port.
 * Assumes all inputs are synchronous to clk, rst_b is power-on reset,
 * and the register master never issues read and write together.
 */
// Functional notes
// - Power-on reset returns every register bit to its reset value.
// - At start-up RC on, crystal off, CPU held in reset at address zero.
// - Port A wake keeps all cold-domain bits except the sleep request.
// - System reset clears system bits; port-config reset only if allowed.
// - System reset keeps clock setup except CPU clock, and resets the CPU.
// - Halt enters standby: CPU stops, clocks and peripherals keep running.
// - Standby ends on any reset or an enabled interrupt or event.
// - Sleep stops every clock and peripheral; only wake logic stays alive.
// - Sleep ends only on power-on reset, reset pin or port A combination.
// - Slept indicator reads one if sleep occurred since software cleared it.
// - Sleep allow clears only on cold reset; zero disables sleep.
// - Port-config reset allow, cold cleared, gates port-config reset.
`timescale 1ns/1ps
`default_nettype none
module omm_top (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Reset sources and wake requests
	input wire logic reset_pin,
	input wire logic porta_wake_reset,
	input wire logic halt_exec,
	input wire logic wake_request,
	// CPU control
	output logic cpu_reset,
	output logic [15:0] cpu_start_addr,
	output logic cpu_stop,
	// Clock generator and peripherals
	output logic rc_osc_enable,
	output logic xtal_enable,
	output logic rc_bias,
	output logic [7:0] rc_trim1,
	output logic [7:0] rc_trim2,
	output logic [1:0] cpu_clock_sel,
	output logic clocks_run,
	output logic periph_run,
	// Reset distribution and mode
	output logic system_reset,
	output logic port_config_reset,
	output logic [1:0] mode
);
	omm_pkg::omm_mode_e state;
	omm_pkg::omm_mode_e next_state;
	logic [7:0] system_control_reg;
	logic external_clock_select;
	logic rc_bias_keep;
	logic [7:0] rc_trim_first;
	logic [7:0] rc_trim_second;
	logic sleep_allow;
	logic port_config_reset_allow;
	logic slept_indicator;
	logic next_slept;
	logic [1:0] cpu_clk;
	logic [1:0] next_cpu_clk;
	logic [7:0] next_rdata;
	logic reset_req;
	logic sys_rst;
	logic sleep_go;
	logic [7:0] system_reset_reg;
	logic [7:0] system_clock_reg;
	logic wr_sys_ctrl;
	logic wr_sys_reset;
	logic wr_sys_clock;
	logic wr_trim1;
	logic wr_trim2;
	logic in_reset;
	logic in_standby;
	logic in_sleep;
	logic slept_clear;
	logic slept_set;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign sleep_allow = system_control_reg[omm_pkg::CTRL_SLEEP_ALLOW];
	assign port_config_reset_allow =
		system_control_reg[omm_pkg::CTRL_PCONF_ALLOW];

	// One write strobe per writable register; the mode offset and unmapped offsets decode to none.
	assign wr_sys_ctrl = reg_wr &&
		hit(reg_addr, omm_pkg::ADDR_SYS_CTRL);
	assign wr_sys_reset = reg_wr &&
		hit(reg_addr, omm_pkg::ADDR_SYS_RESET);
	assign wr_sys_clock = reg_wr &&
		hit(reg_addr, omm_pkg::ADDR_SYS_CLOCK);
	assign wr_trim1 = reg_wr &&
		hit(reg_addr, omm_pkg::ADDR_TRIM_FIRST);
	assign wr_trim2 = reg_wr &&
		hit(reg_addr, omm_pkg::ADDR_TRIM_SECOND);

	// The sleep request bit is never stored: it acts as a command only.
	assign sleep_go = wr_sys_reset &&
		reg_wdata[omm_pkg::RST_SLEEP_REQ] && sleep_allow;

	// Both pin and port A combination are system resets in every mode.
	assign reset_req = reset_pin | porta_wake_reset;

	// Mode decodes shared by the control outputs and the indicator.
	assign in_reset = (state == omm_pkg::OMM_RESET);
	assign in_standby = (state == omm_pkg::OMM_STANDBY);
	assign in_sleep = (state == omm_pkg::OMM_SLEEP);

	// Cold bank: only power-on reset clears it, so a wake keeps it.
	omm_cold_regs u_cold (
		.clk(clk),
		.rst_b(rst_b),
		.wr_ctrl(wr_sys_ctrl),
		.wr_clock(wr_sys_clock),
		.wr_trim_first(wr_trim1),
		.wr_trim_second(wr_trim2),
		.wdata(reg_wdata),
		.system_control_reg(system_control_reg),
		.external_clock_select(external_clock_select),
		.rc_bias_keep(rc_bias_keep),
		.rc_trim_first(rc_trim_first),
		.rc_trim_second(rc_trim_second)
	);

	// Every reset request restarts the full system reset pulse.
	omm_reset_stretch u_stretch (
		.clk(clk),
		.rst_b(rst_b),
		.trigger(reset_req),
		.active(sys_rst)
	);

	// Mode sequencing. Reset beats a sleep request, which beats a halt,
	// so a reset that lands with either still restarts the CPU cleanly.
	// Only ACTIVE takes a sleep request, so standby refuses it as well.
	always_comb begin
		next_state = state;
		unique case (state)
			omm_pkg::OMM_RESET: begin
				if (!sys_rst) begin
					next_state = omm_pkg::OMM_ACTIVE;
				end
			end
			omm_pkg::OMM_ACTIVE: begin
				if (reset_req) begin
					next_state = omm_pkg::OMM_RESET;
				end else if (sleep_go) begin
					next_state = omm_pkg::OMM_SLEEP;
				end else if (halt_exec) begin
					next_state = omm_pkg::OMM_STANDBY;
				end
			end
			omm_pkg::OMM_STANDBY: begin
				if (reset_req) begin
					next_state = omm_pkg::OMM_RESET;
				end else if (wake_request) begin
					next_state = omm_pkg::OMM_ACTIVE;
				end
			end
			omm_pkg::OMM_SLEEP: begin
				// Interrupts and events cannot wake the chip from sleep.
				if (reset_req) begin
					next_state = omm_pkg::OMM_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= omm_pkg::OMM_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Slept indicator events: software clears it by writing a one.
	assign slept_clear = wr_sys_reset && reg_wdata[omm_pkg::RST_SLEPT];
	assign slept_set = in_sleep;

	// The set wins over a clear in the same cycle, so a sleep that
	// software raced against its own clear is never lost.
	always_comb begin
		next_slept = slept_indicator;
		if (slept_clear) begin
			next_slept = 1'b0;
		end
		if (slept_set) begin
			next_slept = 1'b1;
		end
	end

	// Cold domain: only power-on reset clears the indicator.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slept_indicator <= 1'b0;
		end else begin
			slept_indicator <= next_slept;
		end
	end

	// CPU clock select: the only clock field in the system reset domain.
	always_comb begin
		next_cpu_clk = cpu_clk;
		if (wr_sys_clock) begin
			next_cpu_clk =
				reg_wdata[omm_pkg::CLK_CPU_MSB:omm_pkg::CLK_CPU_LSB];
		end
		// A write during the reset pulse is lost on purpose: the CPU
		// must restart on the default clock.
		if (sys_rst) begin
			next_cpu_clk = omm_pkg::CPU_CLK_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_clk <= omm_pkg::CPU_CLK_RESET;
		end else begin
			cpu_clk <= next_cpu_clk;
		end
	end

	// Read view; the sleep request bit always reads back as zero.
	always_comb begin
		system_reset_reg = omm_pkg::READ_ZERO;
		system_reset_reg[omm_pkg::RST_SLEPT] = slept_indicator;
	end

	// Unused clock register bits read as zero.
	always_comb begin
		system_clock_reg = omm_pkg::READ_ZERO;
		system_clock_reg[omm_pkg::CLK_EXT_SEL] = external_clock_select;
		system_clock_reg[omm_pkg::CLK_RC_BIAS] = rc_bias_keep;
		system_clock_reg[omm_pkg::CLK_CPU_MSB:omm_pkg::CLK_CPU_LSB] = cpu_clk;
	end

	// Read mux: an idle cycle returns zero, so data stand one cycle only.
	always_comb begin
		next_rdata = omm_pkg::READ_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				omm_pkg::ADDR_SYS_CTRL: next_rdata = system_control_reg;
				omm_pkg::ADDR_SYS_RESET: next_rdata = system_reset_reg;
				omm_pkg::ADDR_SYS_CLOCK: next_rdata = system_clock_reg;
				omm_pkg::ADDR_TRIM_FIRST: next_rdata = rc_trim_first;
				omm_pkg::ADDR_TRIM_SECOND: next_rdata = rc_trim_second;
				omm_pkg::ADDR_MODE: next_rdata = {6'h00, state};
				default: next_rdata = omm_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= omm_pkg::READ_ZERO;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// CPU control follows the mode register directly.
	assign cpu_reset = in_reset;
	assign cpu_start_addr = omm_pkg::BOOT_ADDR;
	assign cpu_stop = in_standby || in_sleep;

	// Sleep gates every clock, including the RC oscillator. The wake
	// path here stands for the always-on service logic, so it keeps clk.
	assign clocks_run = !in_sleep;
	assign periph_run = !in_sleep;
	assign rc_osc_enable = !in_sleep;
	assign xtal_enable = external_clock_select && !in_sleep;

	// Clock generator settings and reset distribution.
	assign rc_bias = rc_bias_keep;
	assign rc_trim1 = rc_trim_first;
	assign rc_trim2 = rc_trim_second;
	assign cpu_clock_sel = cpu_clk;
	assign system_reset = sys_rst;
	assign port_config_reset = sys_rst && port_config_reset_allow;
	assign mode = state;
endmodule
`default_nettype wire

// file: omm_properties.sv
/*
 * Port assertions for the operating mode manager, bound to omm_top.
 * Assumes one clock and rst_b as the asynchronous power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
module omm_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Requests
	input wire logic reg_wr,
	input wire logic reset_pin,
	input wire logic porta_wake_reset,
	input wire logic halt_exec,
	input wire logic wake_request,
	// Controls
	input wire logic cpu_reset,
	input wire logic [15:0] cpu_start_addr,
	input wire logic cpu_stop,
	input wire logic rc_osc_enable,
	input wire logic xtal_enable,
	input wire logic clocks_run,
	input wire logic periph_run,
	input wire logic system_reset,
	input wire logic port_config_reset,
	input wire logic [1:0] mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic req;
	assign req = reset_pin | porta_wake_reset;
	sequence s_req_end;
		req ##1 !req;
	endsequence
	// Ten cycles high after the last request, then low.
	sequence s_stretch;
		system_reset [*8] ##1 system_reset ##1 system_reset ##1 !system_reset;
	endsequence
	a_boot_addr: assert property (cpu_reset |->
		cpu_start_addr == 16'h0000 && rc_osc_enable) else $error("boot");
	a_sleep_stops: assert property (mode == omm_pkg::OMM_SLEEP |->
		!clocks_run && !periph_run && !rc_osc_enable && !xtal_enable
		&& cpu_stop) else $error("sleep clocks");
	a_standby_runs: assert property (mode == omm_pkg::OMM_STANDBY |->
		cpu_stop && clocks_run && periph_run) else $error("standby");
	a_halt_standby: assert property (mode == omm_pkg::OMM_ACTIVE
		&& halt_exec && !req && !reg_wr |=> mode == omm_pkg::OMM_STANDBY)
		else $error("halt");
	a_standby_wake: assert property (mode == omm_pkg::OMM_STANDBY
		&& wake_request && !req |=> mode == omm_pkg::OMM_ACTIVE)
		else $error("standby wake");
	a_reset_enter: assert property (req |=> mode == omm_pkg::OMM_RESET
		&& system_reset && cpu_reset && clocks_run) else $error("reset");
	a_sleep_holds: assert property (mode == omm_pkg::OMM_SLEEP && !req
		|=> mode == omm_pkg::OMM_SLEEP) else $error("sleep left");
	a_pconf_gate: assert property (port_config_reset |-> system_reset)
		else $error("pconf");
	a_stretch_len: assert property (s_req_end |-> s_stretch)
		else $error("stretch");
	a_reset_release: assert property ($fell(system_reset) && !req |->
		mode == omm_pkg::OMM_RESET ##1 (mode == omm_pkg::OMM_ACTIVE
		&& !cpu_reset)) else $error("release");
endmodule
bind omm_top omm_properties omm_properties_i (.clk, .rst_b, .reg_wr,
	.reset_pin, .porta_wake_reset, .halt_exec, .wake_request, .cpu_reset,
	.cpu_start_addr, .cpu_stop, .rc_osc_enable, .xtal_enable, .clocks_run,
	.periph_run, .system_reset, .port_config_reset, .mode);
`default_nettype wire

// file: omm_cpu_model.sv
/*
 * CPU stand-in: executes a halt on command and raises an event request.
 * Assumes bench commands change just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module omm_cpu_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// From the mode manager
	input wire logic cpu_reset,
	input wire logic cpu_stop,
	// Bench commands
	input wire logic halt_cmd,
	input wire logic irq_cmd,
	// To the mode manager
	output logic halt_exec,
	output logic wake_request
);
	// A stopped or reset CPU fetches nothing, so it cannot halt again.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			halt_exec <= 1'b0;
		else
			halt_exec <= halt_cmd && !cpu_stop && !cpu_reset;
	end
	assign wake_request = irq_cmd;
endmodule
`default_nettype wire

// file: tb.sv
/*
 * Self-checking bench for omm_top with the CPU stand-in.
 * Assumes a 200 MHz clock and the register map of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_b, reg_wr, reg_rd, reset_pin, porta_wake_reset;
	logic halt_cmd, irq_cmd, halt_exec, wake_request, cpu_reset, cpu_stop;
	logic rc_osc_enable, xtal_enable, rc_bias, clocks_run, periph_run;
	logic system_reset, port_config_reset;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rc_trim1, rc_trim2;
	logic [7:0] d, a, ec, t1, t2, ck;
	logic [15:0] cpu_start_addr;
	logic [1:0] cpu_clock_sel, mode;
	logic [31:0] seed;
	int errors, tests_run;
	omm_top omm_top_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .reset_pin, .porta_wake_reset, .halt_exec,
		.wake_request, .cpu_reset, .cpu_start_addr, .cpu_stop,
		.rc_osc_enable, .xtal_enable, .rc_bias, .rc_trim1, .rc_trim2,
		.cpu_clock_sel, .clocks_run, .periph_run, .system_reset,
		.port_config_reset, .mode);
	omm_cpu_model omm_cpu_model_i (.clk, .rst_b, .cpu_reset, .cpu_stop,
		.halt_cmd, .irq_cmd, .halt_exec, .wake_request);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// The watchdog enable bit is sticky and the low nibble reads zero.
	function automatic logic [7:0] ctrl_exp(logic [7:0] o, logic [7:0] v);
		return (o & 8'h10) | (v & 8'hF0);
	endfunction
	task wrap_up;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] ad, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task wait_mode(input logic [1:0] m);
		for (int i = 0; i < 40 && mode !== m; i++) begin
			@(posedge clk);
			#1;
		end
		chk(mode === m, "mode wait");
		if (mode !== m)
			wrap_up;
	endtask
	task pulse(input logic pin, input logic pc);
		@(posedge clk);
		if (pin)
			reset_pin <= 1'b1;
		else
			porta_wake_reset <= 1'b1;
		@(posedge clk);
		reset_pin <= 1'b0;
		porta_wake_reset <= 1'b0;
		#1;
		chk(mode === omm_pkg::OMM_RESET && cpu_reset === 1'b1, "entry");
		chk(port_config_reset === pc, "pconf");
	endtask
	task halt;
		@(posedge clk);
		halt_cmd <= 1'b1;
		@(posedge clk);
		halt_cmd <= 1'b0;
		#1;
	endtask
	initial begin
		seed = 32'h0000_005E;
		{rst_b, reg_wr, reg_rd, reset_pin, porta_wake_reset} = 5'h00;
		{halt_cmd, irq_cmd, reg_addr, reg_wdata} = 18'h0_0000;
		errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		#1;
		chk(cpu_reset === 1'b1 && xtal_enable === 1'b0, "start");
		chk(rc_osc_enable === 1'b1, "rc on");
		@(posedge clk);
		rst_b <= 1'b1;
		wait_mode(omm_pkg::OMM_ACTIVE);
		for (a = 8'h00; a < 8'h07; a++) begin
			rd(a, d);
			chk(d === ((a == 8'h02) ? 8'h02 : 8'h00), "reset value");
		end
		ec = 8'h00;
		repeat (3) begin
			t1 = rnd();
			t2 = rnd();
			ck = (rnd() & 8'h03) | 8'h04;
			d = rnd() & 8'h7F;
			ec = ctrl_exp(ec, d);
			wr(8'h00, d);
			wr(8'h02, ck);
			wr(8'h03, t1);
			wr(8'h04, t2);
			rd(8'h00, d);
			chk(d === ec, "ctrl");
			rd(8'h02, d);
			chk(d === ck && cpu_clock_sel === ck[3:2], "clock reg");
		end
		wr(8'h01, 8'h01);
		chk(mode === omm_pkg::OMM_ACTIVE, "sleep refused");
		ck = ck & 8'hFD;
		wr(8'h02, ck);
		chk(rc_bias === 1'b0, "bias off");
		d = rnd() | 8'h80;
		ec = ctrl_exp(ec, d);
		wr(8'h00, d);
		wr(8'h01, 8'h01);
		chk(mode === omm_pkg::OMM_SLEEP && clocks_run === 1'b0, "sleep");
		chk(rc_osc_enable === 1'b0 && xtal_enable === 1'b0, "osc off");
		// The slot after the sleep request carries no command at all.
		@(posedge clk);
		#1;
		chk(mode === omm_pkg::OMM_SLEEP && cpu_stop === 1'b1, "nop");
		@(posedge clk);
		irq_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		irq_cmd <= 1'b0;
		#1;
		chk(mode === omm_pkg::OMM_SLEEP, "event in sleep");
		pulse(1'b0, ec[6]);
		wait_mode(omm_pkg::OMM_ACTIVE);
		rd(8'h00, d);
		chk(d === ec && rc_trim1 === t1 && rc_trim2 === t2, "cold");
		rd(8'h02, d);
		chk(d === {6'h00, ck[1:0]}, "cpu clock");
		rd(8'h01, d);
		chk(d === 8'h02, "slept");
		wr(8'h01, 8'h02);
		rd(8'h01, d);
		chk(d === 8'h00, "slept clear");
		halt();
		wait_mode(omm_pkg::OMM_STANDBY);
		chk(cpu_stop === 1'b1 && periph_run === 1'b1, "standby");
		@(posedge clk);
		irq_cmd <= 1'b1;
		wait_mode(omm_pkg::OMM_ACTIVE);
		@(posedge clk);
		irq_cmd <= 1'b0;
		d = ec ^ 8'h40;
		ec = ctrl_exp(ec, d);
		wr(8'h00, d);
		halt();
		wait_mode(omm_pkg::OMM_STANDBY);
		pulse(1'b1, ec[6]);
		wait_mode(omm_pkg::OMM_ACTIVE);
		wr(8'h01, 8'h01);
		chk(mode === omm_pkg::OMM_SLEEP, "sleep again");
		pulse(1'b1, ec[6]);
		wait_mode(omm_pkg::OMM_ACTIVE);
		wrap_up;
	end
endmodule
`default_nettype wire
